//--- serial_host_port_framing_tb_top.sv
`timescale 1ns/1ns
module serial_host_port_framing_tb_top;
  import shpf_pkg::*;
  // Small bit count keeps the slowest rate near 2800 cycles per frame
  localparam int unsigned P300 = 256;
  logic        SYS_CLK, RST_N, PSEL, PENABLE, PWRITE, RXD, DSR;
  logic        PREADY, PSLVERR, DTR, TXD;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        er;
  logic [10:0] fr;
  int          num_errors, samples_checked, cycles;

  shpf_uart #(.P_BIT_CYCLES_300(P300)) dut_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RXD(RXD), .DSR(DSR), .DTR(DTR), .TXD(TXD));
  shpf_host_model host_u (.clk(SYS_CLK), .txd(TXD), .dtr(DTR), .rxd(RXD), .dsr(DSR));

  initial
  begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge SYS_CLK)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      close_out;
    end
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'b1 && n < 20)
    begin
      @(posedge SYS_CLK);
      n++;
    end
    q = PRDATA;
    e = PSLVERR;
    chk("pready", 32'h1, {31'h0, PREADY});
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  function automatic logic [10:0] mk(input logic [7:0] d, input shpf_fmt_type f, input logic bad);
    logic b7;
    b7 = (f == FMT_NONE8) ? d[7] : (^d[6:0]) ^ (f == FMT_ODD7) ^ bad;
    return {2'b11, b7, d[6:0], 1'b0};
  endfunction

  task set_cfg(input logic [2:0] s, input shpf_fmt_type f);
    apb(1'b1, ADDR_CFG, {26'h0, f, 1'b0, s}, rd, er);
    chk("cfg err", 32'h0, {31'h0, er});
  endtask

  task tx_one(input logic [2:0] s, input shpf_fmt_type f, input logic [7:0] d);
    set_cfg(s, f);
    apb(1'b1, ADDR_TXDATA, {24'h0, d}, rd, er);
    host_u.recv_frame(P300 >> s, fr);
    chk("tx frame", {21'h0, mk(d, f, 1'b0)}, {21'h0, fr});
  endtask

  task rx_one(input logic [2:0] s, input shpf_fmt_type f, input logic [7:0] d, input logic bad);
    int n;
    n = 0;
    set_cfg(s, f);
    host_u.send_frame(mk(d, f, bad), P300 >> s);
    while (DTR !== 1'b0 && n < 3000)
    begin
      @(posedge SYS_CLK);
      n++;
    end
    chk("dtr busy", 32'h0, {31'h0, DTR});
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("rx status", {30'h0, bad, 1'b1}, {30'h0, rd[3:2]});
    apb(1'b0, ADDR_RXDATA, 32'h0, rd, er);
    chk("rx data", {24'h0, (f == FMT_NONE8) ? d : {1'b0, d[6:0]}}, rd);
    apb(1'b1, ADDR_STATUS, 32'h38, rd, er);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("status cleared", 32'h0, {28'h0, rd[5:2]});
    chk("dtr ready", 32'h1, {31'h0, DTR});
  endtask

  task t_reset;
    chk("dtr reset", 32'h1, {31'h0, DTR});
    chk("txd idle", 32'h1, {31'h0, TXD});
    apb(1'b0, ADDR_CFG, 32'h0, rd, er);
    chk("cfg reset", {26'h0, FMT_NONE8, 1'b0, RATE_9600}, rd);
    $display("test reset done");
  endtask

  task t_tx;
    tx_one(3'h5, FMT_NONE8, 8'ha5);
    for (int s = 0; s < 5; s++)
      tx_one(3'(s), FMT_NONE8, 8'h3c + 8'(s));
    tx_one(3'h2, FMT_EVEN7, 8'h53);
    tx_one(3'h4, FMT_EVEN7, 8'h57);
    tx_one(3'h4, FMT_ODD7, 8'hd3);
    $display("test tx done");
  endtask

  task t_dsr;
    set_cfg(3'h5, FMT_NONE8);
    host_u.set_dsr(1'b0);
    apb(1'b1, ADDR_TXDATA, 32'h81, rd, er);
    // Holding register is full, so this byte must be dropped without an error
    apb(1'b1, ADDR_TXDATA, 32'h22, rd, er);
    chk("drop no err", 32'h0, {31'h0, er});
    repeat (100) @(posedge SYS_CLK);
    chk("txd held", 32'h1, {31'h0, TXD});
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("pending no dsr", 32'h1, {25'h0, rd[6:0] & 7'h41});
    host_u.set_dsr(1'b1);
    host_u.recv_frame(8, fr);
    chk("frame after dsr", {21'h0, mk(8'h81, FMT_NONE8, 1'b0)}, {21'h0, fr});
    apb(1'b1, ADDR_TXDATA, 32'h6e, rd, er);
    // Drop the host ready line in mid-frame; the running character must finish
    fork
      host_u.recv_frame(8, fr);
      begin
        repeat (20) @(posedge SYS_CLK);
        host_u.set_dsr(1'b0);
      end
    join
    chk("frame finished", {21'h0, mk(8'h6e, FMT_NONE8, 1'b0)}, {21'h0, fr});
    host_u.set_dsr(1'b1);
    $display("test dsr done");
  endtask

  task t_rx;
    rx_one(3'h5, FMT_NONE8, 8'hc6, 1'b0);
    rx_one(3'h3, FMT_EVEN7, 8'h35, 1'b0);
    rx_one(3'h5, FMT_EVEN7, 8'h4a, 1'b1);
    rx_one(3'h5, FMT_ODD7, 8'h91, 1'b1);
    $display("test rx done");
  endtask

  task t_err;
    apb(1'b1, 8'h10, 32'h1, rd, er);
    chk("unmapped wr", 32'h1, {31'h0, er});
    apb(1'b0, 8'h14, 32'h0, rd, er);
    chk("unmapped rd", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, ADDR_CFG, 32'h06, rd, er);
    chk("bad rate", 32'h1, {31'h0, er});
    apb(1'b1, ADDR_CFG, 32'h35, rd, er);
    chk("bad fmt", 32'h1, {31'h0, er});
    apb(1'b0, ADDR_CFG, 32'h0, rd, er);
    chk("cfg kept", {26'h0, FMT_ODD7, 1'b0, 3'h5}, rd);
    $display("test errors done");
  endtask

  task t_frame;
    set_cfg(3'h5, FMT_NONE8);
    host_u.glitch(2);
    repeat (16) @(posedge SYS_CLK);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("glitch ignored", 32'h0, {28'h0, rd[5:2]});
    chk("dtr after glitch", 32'h1, {31'h0, DTR});
    // First stop bit forced low; second stop keeps the line at rest
    host_u.send_frame(mk(8'h2d, FMT_NONE8, 1'b0) & 11'h5ff, P300 >> 5);
    repeat (8) @(posedge SYS_CLK);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("stop error", 32'h5, {28'h0, rd[5:2]});
    apb(1'b0, ADDR_RXDATA, 32'h0, rd, er);
    chk("rx data bad stop", 32'h2d, rd);
    apb(1'b1, ADDR_STATUS, 32'h38, rd, er);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk("stop flag cleared", 32'h0, {28'h0, rd[5:2]});
    $display("test frame done");
  endtask

  initial
  begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (10) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    t_reset;
    t_tx;
    t_dsr;
    t_rx;
    t_err;
    t_frame;
    close_out;
  end
endmodule

//--- shpf_host_model.sv
`timescale 1ns/1ns
module shpf_host_model
(
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic dtr,
  output logic      rxd,
  output logic      dsr
);
  initial
  begin
    rxd = 1'b1;
    dsr = 1'b1;
  end

  // Host answers with its own ready line only; no other handshake exists
  task set_dsr(input logic v);
    @(posedge clk);
    dsr <= v;
  endtask

  // Short low pulse that the receiver must not take for a start bit
  task glitch(input int c);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (c) @(posedge clk);
    rxd <= 1'b1;
  endtask

  // Same rate and framing as the port; line rests at stop level after the frame
  task send_frame(input logic [10:0] f, input int p);
    int n;
    n = 0;
    while (dtr !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk);
      rxd <= f[i];
      repeat (p - 1) @(posedge clk);
    end
  endtask

  // Mid-bit sampling, so a wrong bit period shows up as wrong bits
  task recv_frame(input int p, output logic [10:0] f);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (p / 2) @(posedge clk);
    for (int i = 0; i < 11; i++)
    begin
      f[i] = txd;
      repeat (p) @(posedge clk);
    end
  endtask
endmodule

//--- shpf_pkg.sv
// Contract
// R1 - Bit rate is one of 300 to 9600 baud, 9600 after reset.
// R2 - Format is none/8 data (default), even/7 data or odd/7 data.
// R3 - Each character starts with exactly one start bit.
// R4 - Each character ends with exactly two stop bits.
// R5 - Frame: start, 7 data plus parity or 8 data, two stops.
// R6 - Port is terminal equipment; DTR and DSR are the only handshake.
// R7 - Rate, parity and width come from local configuration and steer framing.
// R8 - Host uses the same rate, parity, width, one start, two stops.
// R9 - Host sends the remote-mode command before instrument commands.
// R10 - Raise DTR when able to accept; start characters only while DSR high.
// R11 - LSB first; parity over seven data bits; bad received parity is flagged.
package shpf_pkg;

  localparam int unsigned CLK_HZ    = 100_000_000;
  localparam int unsigned BAUD_MIN  = 300;
  // Faster rates are the slowest one doubled per select step
  localparam int unsigned BIT_CYCLES_300 = CLK_HZ / BAUD_MIN;
  localparam int          CNT_W     = 19;

  localparam logic [2:0] RATE_9600  = 3'h5;
  localparam logic [2:0] RATE_MAX   = 3'h5;

  typedef enum logic [1:0] {
    FMT_NONE8 = 2'h0,
    FMT_EVEN7 = 2'h1,
    FMT_ODD7  = 2'h2
  } shpf_fmt_type;

  localparam int          FRAME_BITS = 11;
  localparam logic [3:0]  TX_LAST    = 4'ha;
  localparam logic [3:0]  RX_LAST    = 4'h9;
  localparam logic [3:0]  PAR_IDX    = 4'h8;
  localparam logic [3:0]  STOP_IDX   = 4'h9;
  localparam logic        START_LVL  = 1'b0;
  localparam logic        STOP_LVL   = 1'b1;

  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_TXDATA = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;

  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_FMT_LSB  = 4;
  localparam int ST_TX_FULL   = 0;
  localparam int ST_TX_BUSY   = 1;
  localparam int ST_RX_VALID  = 2;
  localparam int ST_PAR_ERR   = 3;
  localparam int ST_FRM_ERR   = 4;
  localparam int ST_OVERRUN   = 5;
  localparam int ST_DSR       = 6;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } shpf_tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } shpf_rx_state_type;

endpackage

//--- shpf_tx.sv
`timescale 1ns/1ns
module shpf_tx
  import shpf_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [CNT_W-1:0] period,
  input  wire shpf_fmt_type     fmt,
  input  wire logic             pending,
  input  wire logic [7:0]       data,
  input  wire logic             dsr,
  output wire logic             take,
  output wire logic             busy,
  output logic                  txd
);

  shpf_tx_state_type     state;
  logic [CNT_W-1:0]      cnt;
  logic [CNT_W-1:0]      period_q;
  logic [3:0]            bit_n;
  logic [FRAME_BITS-2:0] shift;
  logic [7:0]            data_q;
  shpf_fmt_type          fmt_q;
  logic                  par;
  logic [FRAME_BITS-1:0] frame;

  // A character in flight keeps running even if DSR drops
  assign take = pending && dsr && (state == TX_IDLE); // R10
  assign busy = (state == TX_SEND);
  assign par  = (fmt == FMT_ODD7) ^ (^data[6:0]); // R11
  assign frame = {STOP_LVL, STOP_LVL, (fmt == FMT_NONE8) ? data[7] : par, data[6:0], START_LVL}; // R3 R4 R5

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state    <= TX_IDLE;
      txd      <= STOP_LVL;
      cnt      <= '0;
      period_q <= '0;
      bit_n    <= '0;
      shift    <= '0;
      data_q   <= '0;
      fmt_q    <= FMT_NONE8;
    end
    else
    begin
      unique case (state)
        TX_IDLE:
        begin
          if (take)
          begin
            state    <= TX_SEND;
            txd      <= frame[0];
            shift    <= frame[FRAME_BITS-1:1];
            bit_n    <= '0;
            cnt      <= period - 1'b1;
            period_q <= period;
            data_q   <= data;
            fmt_q    <= fmt;
          end
        end
        TX_SEND:
        begin
          if (cnt != '0)
            cnt <= cnt - 1'b1;
          else if (bit_n == TX_LAST)
            state <= TX_IDLE;
          else
          begin
            txd   <= shift[0]; // R11
            shift <= shift >> 1;
            bit_n <= bit_n + 1'b1;
            cnt   <= period_q - 1'b1;
          end
        end
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_tx_dsr_gate;
    $rose(busy) |-> $past(dsr) && $past(pending);
  endproperty
  a_tx_dsr_gate: assert property (p_tx_dsr_gate) else $error("Frame started without DSR"); // R10

  property p_tx_start;
    $rose(busy) |-> txd == START_LVL && bit_n == 4'h0;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("Start bit missing"); // R3

  property p_tx_stop;
    busy && bit_n >= STOP_IDX |-> txd == STOP_LVL;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("Stop bit not high"); // R4

  property p_tx_len;
    $fell(busy) |-> $past(bit_n) == TX_LAST && $past(cnt) == '0;
  endproperty
  a_tx_len: assert property (p_tx_len) else $error("Frame length wrong"); // R5

  property p_tx_hold;
    busy && cnt != '0 |=> $stable(txd);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("Line moved inside a bit"); // R1

  property p_tx_parity;
    busy && bit_n == PAR_IDX && fmt_q != FMT_NONE8 |-> txd == ((fmt_q == FMT_ODD7) ^ (^data_q[6:0]));
  endproperty
  a_tx_parity: assert property (p_tx_parity) else $error("Parity bit wrong"); // R11

  c_tx_frame: cover property ($fell(busy));
  c_tx_stall: cover property (pending && !dsr && !busy);

endmodule

//--- shpf_uart.sv
`timescale 1ns/1ns
module shpf_uart
  import shpf_pkg::*;
#(
  parameter int unsigned P_BIT_CYCLES_300 = BIT_CYCLES_300
)
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RXD,
  input  wire logic        DSR,
  output logic             DTR,
  output wire logic        TXD
);

  logic [2:0]        rate_sel;
  shpf_fmt_type      fmt;
  logic [CNT_W-1:0]  period;
  logic              tx_full;
  logic [7:0]        tx_data;
  logic              tx_take;
  logic              tx_busy;
  logic              rx_valid;
  logic [7:0]        rx_data;
  logic              par_err;
  logic              frm_err;
  logic              overrun;
  shpf_rx_state_type rx_state;
  logic [CNT_W-1:0]  rx_cnt;
  logic [3:0]        rx_bit;
  logic [9:0]        rx_shift;
  logic              rx_done;
  logic              rx_par_bad;
  logic              rx_stop_bad;
  logic              setup;
  logic              access;
  logic              wr;
  logic              rd;
  logic              cfg_ok;
  logic              unmapped;
  logic [31:0]       next_prdata;

  // Faster rates are exact doublings, so one divider constant serves all six
  assign period = CNT_W'(P_BIT_CYCLES_300 >> rate_sel); // R1

  // One wait state keeps PREADY and PRDATA straight off flip-flops
  assign setup    = PSEL && PENABLE && !PREADY;
  assign access   = PSEL && PENABLE && PREADY;
  assign wr       = access && PWRITE && !PSLVERR;
  assign rd       = access && !PWRITE;
  assign cfg_ok   = (PWDATA[CFG_RATE_LSB+:3] <= RATE_MAX) && (PWDATA[CFG_FMT_LSB+:2] != 2'h3); // R2
  assign unmapped = !(PADDR inside {ADDR_CFG, ADDR_TXDATA, ADDR_STATUS, ADDR_RXDATA});

  always_comb
  begin
    next_prdata = '0;
    unique case (PADDR)
      ADDR_CFG:
      begin
        next_prdata[CFG_RATE_LSB+:3] = rate_sel;
        next_prdata[CFG_FMT_LSB+:2]  = fmt;
      end
      ADDR_STATUS:
      begin
        next_prdata[ST_TX_FULL]  = tx_full;
        next_prdata[ST_TX_BUSY]  = tx_busy;
        next_prdata[ST_RX_VALID] = rx_valid;
        next_prdata[ST_PAR_ERR]  = par_err;
        next_prdata[ST_FRM_ERR]  = frm_err;
        next_prdata[ST_OVERRUN]  = overrun;
        next_prdata[ST_DSR]      = DSR;
      end
      ADDR_RXDATA: next_prdata[7:0] = rx_data;
      default: next_prdata = '0;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end
    else
    begin
      PREADY  <= setup;
      PSLVERR <= setup && (unmapped || (PWRITE && PADDR == ADDR_CFG && !cfg_ok));
      PRDATA  <= (setup && !PWRITE) ? next_prdata : '0;
    end
  end

  // Configuration is the local operator setting; a transmit frame in flight keeps its own, the receiver uses it live
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      rate_sel <= RATE_9600; // R1
      fmt      <= FMT_NONE8; // R2
    end
    else if (wr && PADDR == ADDR_CFG)
    begin
      rate_sel <= PWDATA[CFG_RATE_LSB+:3]; // R7
      fmt      <= shpf_fmt_type'(PWDATA[CFG_FMT_LSB+:2]); // R7
    end
  end

  // A write while the holding register is full is dropped
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      tx_full <= 1'b0;
      tx_data <= '0;
    end
    else if (wr && PADDR == ADDR_TXDATA && !tx_full)
    begin
      tx_full <= 1'b1;
      tx_data <= PWDATA[7:0];
    end
    else if (tx_take)
      tx_full <= 1'b0;
  end

  shpf_tx u_tx (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .period  (period),
    .fmt     (fmt),
    .pending (tx_full),
    .data    (tx_data),
    .dsr     (DSR),
    .take    (tx_take),
    .busy    (tx_busy),
    .txd     (TXD)
  );

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      rx_state <= RX_IDLE;
      rx_cnt   <= '0;
      rx_bit   <= '0;
      rx_shift <= '0;
      rx_done  <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      unique case (rx_state)
        RX_IDLE:
        begin
          if (RXD == START_LVL)
          begin
            rx_state <= RX_START;
            rx_cnt   <= period >> 1;
          end
        end
        RX_START:
        begin
          if (rx_cnt != '0)
            rx_cnt <= rx_cnt - 1'b1;
          else if (RXD != START_LVL)
            rx_state <= RX_IDLE; // R3
          else
          begin
            rx_state <= RX_DATA;
            rx_bit   <= '0;
            rx_cnt   <= period - 1'b1;
          end
        end
        RX_DATA:
        begin
          if (rx_cnt != '0)
            rx_cnt <= rx_cnt - 1'b1;
          else
          begin
            rx_shift <= {RXD, rx_shift[9:1]}; // R11
            rx_bit   <= rx_bit + 1'b1;
            rx_cnt   <= period - 1'b1;
            if (rx_bit == RX_LAST)
            begin
              rx_state <= RX_IDLE; // R5
              rx_done  <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign rx_par_bad  = (fmt != FMT_NONE8) && (rx_shift[7] != ((fmt == FMT_ODD7) ^ (^rx_shift[6:0]))); // R11
  assign rx_stop_bad = (rx_shift[8] != STOP_LVL) || (rx_shift[9] != STOP_LVL); // R4

  // A new character wins over a read or a clear in the same cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      rx_valid <= 1'b0;
      rx_data  <= '0;
      overrun  <= 1'b0;
      par_err  <= 1'b0;
      frm_err  <= 1'b0;
    end
    else
    begin
      if (rx_done && (!rx_valid || (rd && PADDR == ADDR_RXDATA)))
      begin
        rx_valid <= 1'b1;
        rx_data  <= (fmt == FMT_NONE8) ? rx_shift[7:0] : {1'b0, rx_shift[6:0]};
      end
      else if (rd && PADDR == ADDR_RXDATA)
        rx_valid <= 1'b0;
      if (rx_done && rx_valid && !(rd && PADDR == ADDR_RXDATA))
        overrun <= 1'b1;
      else if (wr && PADDR == ADDR_STATUS && PWDATA[ST_OVERRUN])
        overrun <= 1'b0;
      if (rx_done && rx_par_bad)
        par_err <= 1'b1; // R11
      else if (wr && PADDR == ADDR_STATUS && PWDATA[ST_PAR_ERR])
        par_err <= 1'b0;
      if (rx_done && rx_stop_bad)
        frm_err <= 1'b1;
      else if (wr && PADDR == ADDR_STATUS && PWDATA[ST_FRM_ERR])
        frm_err <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      DTR <= 1'b1;
    else
      DTR <= !rx_valid; // R6 R10
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  property p_dtr_follow;
    rx_valid |=> !DTR;
  endproperty
  a_dtr_follow: assert property (p_dtr_follow) else $error("DTR high with character waiting"); // R10

  property p_cfg_apply;
    wr && PADDR == ADDR_CFG |=> rate_sel == $past(PWDATA[CFG_RATE_LSB+:3]) && fmt == $past(PWDATA[CFG_FMT_LSB+:2]);
  endproperty
  a_cfg_apply: assert property (p_cfg_apply) else $error("Configuration write not applied"); // R7

  property p_fmt_legal;
    fmt != 2'h3 && rate_sel <= RATE_MAX;
  endproperty
  a_fmt_legal: assert property (p_fmt_legal) else $error("Illegal configuration held"); // R2

  property p_rx_parity;
    rx_done && rx_par_bad |=> par_err;
  endproperty
  a_rx_parity: assert property (p_rx_parity) else $error("Parity error not flagged"); // R11

  property p_rx_false_start;
    rx_state == RX_START && rx_cnt == '0 && RXD |=> rx_state == RX_IDLE;
  endproperty
  a_rx_false_start: assert property (p_rx_false_start) else $error("Glitch accepted as start"); // R3

  c_rx_char: cover property (rx_done && !rx_par_bad && !rx_stop_bad);
  c_rx_par:  cover property (rx_done && rx_par_bad);

endmodule
